// >>> src/ldsr_defines.vh
// Constants for the lane drive setting register bank
`ifndef LDSR_DEFINES_VH
`define LDSR_DEFINES_VH
`define LDSR_IDX_LANE0 12'h103
`define LDSR_IDX_LANE1 12'h104
`define LDSR_IDX_LANE2 12'h105
`define LDSR_ADDR_CTRL 12'h500
`define LDSR_ADDR_STAT 12'h504
`define LDSR_SWING_LSB 0
`define LDSR_SWING_MSB 1
`define LDSR_SWMAX_BIT 2
`define LDSR_PREEM_LSB 3
`define LDSR_PREEM_MSB 4
`define LDSR_PEMAX_BIT 5
`define LDSR_LANE_RST 6'h00
`define LDSR_PAT_LSB 0
`define LDSR_PAT_MSB 1
`define LDSR_CNT_LSB 8
`define LDSR_CNT_MSB 12
`define LDSR_PAT_OFF 2'h0
`define LDSR_PAT_TP1 2'h1
`define LDSR_PAT_TP2 2'h2
`define LDSR_CNT_1 5'h01
`define LDSR_CNT_2 5'h02
`define LDSR_CNT_4 5'h04
`endif

// >>> src/ldsr_regs.v
// Lane drive setting register bank with AHB-Lite slave and per-lane drive outputs
`timescale 1ns/1ps
`include "ldsr_defines.vh"
//
// Summary of operation
// - Bits 1:0 hold swing level zero to three
// - Bits 4:3 hold pre-emphasis level, none to three
// - Bits 7:6 always read as zero
// - Lanes one and two share lane zero layout
// - Lane zero register is writable and readable
// - Pattern 01 uses swing, 10 adds emphasis
// - Lane count selects which lanes are driven
module ldsr_regs #(
  parameter NLANES = 3
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_ff,
  output reg hreadyout_ff,
  output reg hresp_ff,
  output reg [NLANES-1:0] lane_en_ff,
  output reg [2*NLANES-1:0] lane_swing_ff,
  output reg [2*NLANES-1:0] lane_preemph_ff,
  output reg [NLANES-1:0] lane_swmax_ff,
  output reg [NLANES-1:0] lane_pemax_ff
);

// Lane zero sits at four times its register index on the byte-addressed bus
localparam [31:0] LANE0_BYTE = `LDSR_IDX_LANE0 * 4;

////////////////////////////////////////////////////////////////////////////////
// Bus request capture

reg pend_ff;
reg pend_wr_ff;
reg [11:0] pend_addr_ff;
reg [1:0] pattern_ff;
reg [4:0] lane_cnt_ff;
wire take;
wire wr_ctrl;

// Each transfer gets one wait state while ce stays high, so read data can come from a flop
assign take = hsel & htrans[1] & hready & ~pend_ff;
assign wr_ctrl = pend_ff & pend_wr_ff & (pend_addr_ff == `LDSR_ADDR_CTRL);

reg nxt_pend;
reg nxt_pend_wr;
reg [11:0] nxt_pend_addr;
reg nxt_readyout;

// Address and direction hold after the data phase; pend_ff alone qualifies them
always @* begin
  nxt_pend = 1'b0;
  nxt_pend_wr = pend_wr_ff;
  nxt_pend_addr = pend_addr_ff;
  nxt_readyout = 1'b1;
  if (take) begin
    nxt_pend = 1'b1;
    nxt_pend_wr = hwrite;
    nxt_pend_addr = haddr[11:0];
    nxt_readyout = 1'b0;
  end
end

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    pend_ff <= 1'b0;
    pend_wr_ff <= 1'b0;
    pend_addr_ff <= 12'h000;
    hreadyout_ff <= 1'b1;
    hresp_ff <= 1'b0;
  end else if (ce) begin
    // Every transfer completes, so the response never leaves OKAY
    hresp_ff <= 1'b0;
    pend_ff <= nxt_pend;
    pend_wr_ff <= nxt_pend_wr;
    pend_addr_ff <= nxt_pend_addr;
    hreadyout_ff <= nxt_readyout;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Lane registers, one per lane

wire [6*NLANES-1:0] lane_rd;
wire train_on;
wire emph_on;

// Reserved pattern code falls through both compares and acts as training off
assign train_on = (pattern_ff == `LDSR_PAT_TP1) || (pattern_ff == `LDSR_PAT_TP2);
assign emph_on = (pattern_ff == `LDSR_PAT_TP2);

genvar g;
generate
  for (g = 0; g < NLANES; g = g + 1) begin : g_lane
    reg [5:0] set_ff;
    reg nxt_en;
    reg [1:0] nxt_swing;
    reg [1:0] nxt_preem;
    reg nxt_swmax;
    reg nxt_pemax;
    wire [31:0] lane_byte_addr;
    wire [11:0] lane_addr;
    wire [1:0] swing;
    wire [1:0] preem;
    wire rd_hit;
    wire wr_lane;
    wire active;

    // Byte address is four times the register index; only 12 bits are decoded
    assign lane_byte_addr = LANE0_BYTE + 4 * g;
    assign lane_addr = lane_byte_addr[11:0];
    assign rd_hit = (pend_addr_ff == lane_addr);
    assign wr_lane = pend_ff & pend_wr_ff & rd_hit;
    assign swing = set_ff[`LDSR_SWING_MSB:`LDSR_SWING_LSB];
    assign preem = set_ff[`LDSR_PREEM_MSB:`LDSR_PREEM_LSB];
    assign lane_rd[6*g +: 6] = rd_hit ? set_ff : 6'h00;

    // Ceiling flags are stored as written; the writer owns their meaning
    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        set_ff <= `LDSR_LANE_RST;
      end else if (ce && wr_lane) begin
        set_ff <= hwdata[5:0];
      end
    end

    // Lane count decode: reserved counts leave every lane idle
    assign active = (lane_cnt_ff == `LDSR_CNT_4) ||
                    (lane_cnt_ff == `LDSR_CNT_2 && g < 2) ||
                    (lane_cnt_ff == `LDSR_CNT_1 && g == 0);

    // Idle lanes drive all zeros so the transmitter never sees a stale level
    always @* begin
      nxt_en = 1'b0;
      nxt_swing = 2'h0;
      nxt_preem = 2'h0;
      nxt_swmax = 1'b0;
      nxt_pemax = 1'b0;
      if (active && train_on) begin
        nxt_en = 1'b1;
        nxt_swing = swing;
        nxt_swmax = set_ff[`LDSR_SWMAX_BIT];
        // Emphasis only applies while the second pattern runs
        if (emph_on) begin
          nxt_preem = preem;
          nxt_pemax = set_ff[`LDSR_PEMAX_BIT];
        end
      end
    end

    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lane_en_ff[g] <= 1'b0;
      end else if (ce) begin
        lane_en_ff[g] <= nxt_en;
      end
    end

    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lane_swing_ff[2*g +: 2] <= 2'h0;
      end else if (ce) begin
        lane_swing_ff[2*g +: 2] <= nxt_swing;
      end
    end

    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lane_preemph_ff[2*g +: 2] <= 2'h0;
      end else if (ce) begin
        lane_preemph_ff[2*g +: 2] <= nxt_preem;
      end
    end

    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lane_swmax_ff[g] <= 1'b0;
      end else if (ce) begin
        lane_swmax_ff[g] <= nxt_swmax;
      end
    end

    always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lane_pemax_ff[g] <= 1'b0;
      end else if (ce) begin
        lane_pemax_ff[g] <= nxt_pemax;
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Training control register

reg [1:0] nxt_pattern;
reg [4:0] nxt_lane_cnt;

// The reserved pattern code is stored as written so software reads back what it wrote
always @* begin
  nxt_pattern = pattern_ff;
  nxt_lane_cnt = lane_cnt_ff;
  if (wr_ctrl) begin
    nxt_pattern = hwdata[`LDSR_PAT_MSB:`LDSR_PAT_LSB];
    nxt_lane_cnt = hwdata[`LDSR_CNT_MSB:`LDSR_CNT_LSB];
  end
end

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    pattern_ff <= `LDSR_PAT_OFF;
    lane_cnt_ff <= 5'h00;
  end else if (ce) begin
    pattern_ff <= nxt_pattern;
    lane_cnt_ff <= nxt_lane_cnt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read data

reg [31:0] nxt_rdata;
reg [5:0] lane_rd_any;
integer i;

// At most one lane matches, so an OR of the per-lane words is the mux
always @* begin
  nxt_rdata = 32'h00000000;
  lane_rd_any = 6'h00;
  for (i = 0; i < NLANES; i = i + 1) begin
    lane_rd_any = lane_rd_any | lane_rd[6*i +: 6];
  end
  nxt_rdata = {26'h0000000, lane_rd_any};
  if (pend_addr_ff == `LDSR_ADDR_CTRL) begin
    nxt_rdata = {19'h00000, lane_cnt_ff, 6'h00, pattern_ff};
  end
  if (pend_addr_ff == `LDSR_ADDR_STAT) begin
    nxt_rdata = {{(32-NLANES){1'b0}}, lane_en_ff};
  end
end

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    hrdata_ff <= 32'h00000000;
  end else if (ce && pend_ff && !pend_wr_ff) begin
    hrdata_ff <= nxt_rdata;
  end
end

endmodule

// >>> dv/ldsr_partner.sv
// Training controller model: three swing levels, three emphasis levels
`timescale 1ns/1ps
module ldsr_partner (
  input wire [1:0] swing,
  input wire [1:0] preemph,
  output wire [7:0] lane_byte
);
  // One setting at a time, redrawn by the bench for each lane; the top codes carry the ceiling flags
  assign lane_byte = {2'h0, preemph == 2'h2, preemph, swing == 2'h2, swing};
endmodule

// >>> dv/ldsr_regs_monitor.sv
// Bus timing and lane gating checker
`timescale 1ns/1ps
module ldsr_regs_monitor #(parameter NLANES = 3) (
  input wire hclk, hresetn, ce, hsel, hready, hreadyout_ff, hresp_ff,
  input wire [1:0] htrans,
  input wire [31:0] hrdata_ff,
  input wire [NLANES-1:0] lane_en_ff, lane_swmax_ff, lane_pemax_ff,
  input wire [2*NLANES-1:0] lane_swing_ff, lane_preemph_ff
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_take_wait: assert property (ce && hsel && htrans[1] && hready |=> !hreadyout_ff) else $error("no wait");
  a_one_wait: assert property (ce && !hreadyout_ff |=> hreadyout_ff) else $error("long wait");
  a_resp_okay: assert property (!hresp_ff) else $error("bad response");
  a_rd_hold: assert property (!hreadyout_ff |-> $stable(hrdata_ff)) else $error("read data moved");
  a_sw_gate: assert property (!lane_en_ff[0] |-> !lane_swing_ff[1:0]) else $error("swing on idle lane");
  a_pe_gate: assert property (!lane_en_ff[1] |-> !lane_preemph_ff[3:2]) else $error("emphasis on idle lane");
  a_max_gate: assert property (!((lane_swmax_ff | lane_pemax_ff) & ~lane_en_ff)) else $error("flag on idle");
  a_lane_set: assert property (lane_en_ff inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("lane gap");
  c_all: cover property (&lane_en_ff);
  c_emph: cover property (|lane_preemph_ff);
  c_wait: cover property (!hreadyout_ff);
endmodule
bind ldsr_regs ldsr_regs_monitor #(.NLANES(NLANES)) ldsr_regs_monitor_inst (.*);

// >>> dv/ldsr_regs_bench.sv
// Lane drive setting bank bench
`timescale 1ns/1ps
module ldsr_regs_bench;
  // Clock enable drops once near the end to check the freeze path
  logic hclk = 1'h0, hresetn = 1'h0, ce = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] ps = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, d;
  wire [31:0] hrdata_ff;
  wire hreadyout_ff, hresp_ff, hready = hreadyout_ff;
  wire [2:0] lane_en_ff, lane_swmax_ff, lane_pemax_ff;
  wire [5:0] lane_swing_ff, lane_preemph_ff;
  wire [7:0] lane_byte;
  int mdl[4], error_cnt = 0, n_tests = 0, cyc = 0, g, t;
  ldsr_regs ldsr_regs_inst (.*);
  ldsr_partner ldsr_partner_inst (.swing(ps[1:0]), .preemph(ps[3:2]), .lane_byte(lane_byte));
  always #4 hclk = ~hclk;
  task summarize;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, v);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
    do @(posedge hclk); while (hready !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, wd};
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata_ff;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize;
    end
  end
  initial begin
    void'($urandom(32'h4e44));
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    // Random mix over three lanes and the unmapped word after them
    repeat (40) begin
      g = $urandom % 4;
      d = $urandom;
      bus(d[31], 32'h40C + 4 * g, d);
      if (d[31] && g < 3) mdl[g] = d[5:0];
      if (!d[31]) chk("lane_reg", mdl[g], r);
    end
    $display("register test done");
    for (g = 0; g < 3; g++) begin
      ps <= $urandom % 3 * 4 + $urandom % 3;
      @(posedge hclk);
      bus(1'h1, 32'h40C + 4 * g, {24'h0, lane_byte});
      mdl[g] = lane_byte;
    end
    // Every pattern code against lane counts 0, 1, 2 and 4
    for (int p = 0; p < 16; p++) begin
      t = p / 4;
      g = p % 4;
      @(posedge hclk);
      bus(1'h1, 32'h500, (g + g / 3) << 8 | t);
      @(posedge hclk);
      #1;
      d = 32'h0;
      for (int k = 0; k < (t % 3 ? g : 0); k++) begin
        d[18 + k] = 1'h1;
        {d[3 + k], d[12 + 2 * k +: 2]} = mdl[k][2:0];
        if (t == 2) {d[k], d[6 + 2 * k +: 2]} = mdl[k][5:3];
      end
      chk("lanes", d, {lane_en_ff, lane_swing_ff, lane_preemph_ff, lane_swmax_ff, lane_pemax_ff});
      bus(1'h0, 32'h504, 32'h0);
      chk("stat", d[20:18], r);
      bus(1'h0, 32'h500, 32'h0);
      chk("ctrl", (g + g / 3) << 8 | t, r);
    end
    $display("lane test done");
    // A write presented while ce is low must leave no trace
    ce <= 1'h0;
    bus(1'h1, 32'h40C, ~mdl[0]);
    ce <= 1'h1;
    bus(1'h0, 32'h40C, 32'h0);
    chk("ce_freeze", mdl[0], r);
    $display("freeze test done");
    summarize;
  end
endmodule
